// >>> include/dcbs_pkg.sv
/*
 * Shared constants and types for the dual-core boot sequencer: the fixed boot
 * vectors, the memory map, the register map, the sequencer states and the
 * packed carriers used on its ports.
 * Assumes a 32-bit system address space and a 12-bit byte-addressed register window.
 */
package dcbs_pkg;

	// ------------------------------------------------------------------
	// Boot vectors, fixed in hardware
	// ------------------------------------------------------------------
	localparam logic [31:0] VEC_SLOW_CORE   = 32'h0000_0000; // Boot ROM of the low-power core
	localparam logic [31:0] VEC_FAST_CORE   = 32'h1010_0000; // Instruction ROM of the fast core

	// ------------------------------------------------------------------
	// Memory map
	// ------------------------------------------------------------------
	localparam logic [31:0] FAST_SRAM_BASE  = 32'h1000_0000; // 512KB
	localparam logic [31:0] FAST_SRAM_SIZE  = 32'h0008_0000;
	localparam logic [31:0] SLOW_SRAM_BASE  = 32'h0008_0000; // 64KB
	localparam logic [31:0] SLOW_SRAM_SIZE  = 32'h0001_0000;
	localparam logic [31:0] PSRAM_BASE      = 32'h0200_0000; // 4MB window
	localparam logic [31:0] PSRAM_SIZE      = 32'h0040_0000;
	localparam logic [31:0] RET_SRAM_BASE   = 32'h000c_0000; // 1KB, always powered
	localparam logic [31:0] RET_SRAM_SIZE   = 32'h0000_0400;

	// ------------------------------------------------------------------
	// Crystal choice held in the fuse
	// ------------------------------------------------------------------
	localparam int          XTAL_HI_HZ      = 26000000;      // Fuse bit high
	localparam int          XTAL_LO_HZ      = 20000000;      // Fuse bit low

	// ------------------------------------------------------------------
	// Register map (byte offsets) and field positions
	// ------------------------------------------------------------------
	localparam logic [11:0] OFS_CTRL        = 12'h000;
	localparam logic [11:0] OFS_STATUS      = 12'h004;
	localparam logic [11:0] OFS_CAUSE       = 12'h008;
	localparam logic [11:0] OFS_IRQ_STAT    = 12'h00c;
	localparam logic [11:0] OFS_IRQ_MASK    = 12'h010;
	localparam logic [11:0] OFS_SAU_BASE    = 12'h014;
	localparam logic [11:0] OFS_SAU_LIMIT   = 12'h018;
	localparam logic [11:0] OFS_SAU_CTRL    = 12'h01c;
	localparam logic [1:0]  RRAM_WIN_SEL    = 2'h1;          // Address bits 11:10 of 0x400..0x7ff
	localparam int          CTRL_GO_BIT     = 0;
	localparam int          SAU_EN_BIT      = 0;
	localparam int          IRQ_W           = 3;
	localparam int          IRQ_FAST_UP     = 0;
	localparam int          IRQ_DEAD_LOOP   = 1;
	localparam int          IRQ_CAUSE_SEEN  = 2;
	localparam logic [2:0]  RST_IRQ_MASK    = 3'h0;
	localparam logic [31:0] RST_SAU_WORD    = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_SAMPLE = 4'h0, ST_ISP  = 4'h1, ST_SEARCH = 4'h2, ST_USER = 4'h3,
		ST_DEAD   = 4'h4, ST_PLL  = 4'h5, ST_FCAL   = 4'h6, ST_PWR  = 4'h7,
		ST_RUN    = 4'h8
	} dcbs_state_t;

	typedef enum logic [2:0] {
		RGN_NONE = 3'h0, RGN_SLOW_SRAM = 3'h1, RGN_RET_SRAM = 3'h2,
		RGN_PSRAM = 3'h3, RGN_FAST_SRAM = 3'h4
	} dcbs_region_t;

	typedef struct packed {
		logic cause_brownout;
		logic cause_deep_sleep_wake;
		logic cause_fast_core_watchdog;
		logic cause_fast_core_sys_reset;
		logic cause_slow_core_watchdog;
		logic cause_slow_core_sys_reset;
	} dcbs_cause_t;

	typedef struct packed {
		logic pll_pwr_en;
		logic flash_cal_req;
		logic fast_pwr_en;
	} dcbs_pwr_t;

	typedef struct packed {
		dcbs_region_t region;
		logic         secure;
	} dcbs_probe_t;

endpackage

// >>> rtl/dcbs_ret_ram.sv
/*
 * Retention SRAM: word memory with byte-lane writes and a registered read port.
 * Assumes it sits in the always-on domain; it has no reset, so its contents
 * survive every reset except loss of power.
 */
`timescale 1ns/1ps
module dcbs_ret_ram import dcbs_pkg::*; #(
	parameter int WORDS = 256,
	parameter int AW    = 8
) (
	// Clock
	input  wire logic          clk,
	// Write side
	input  wire logic          we,
	input  wire logic [3:0]    be,
	input  wire logic [AW-1:0] addr,
	input  wire logic [31:0]   wdata,
	// Read side
	output logic      [31:0]   rdata
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	if (WORDS != (1 << AW)) begin : g_bad_size
		$error("dcbs_ret_ram: WORDS must equal 2**AW");
	end

	// One array and one read register per byte lane, so no array has two writers
	for (genvar i = 0; i < 4; i++) begin : g_lane
		logic [7:0] mem [WORDS];  // Kept through deep sleep
		always_ff @(posedge clk) begin
			if (we && be[i]) begin
				mem[addr] <= wdata[8*i +: 8];
			end
			rdata[8*i +: 8] <= mem[addr];  // Registered read, one cycle after the address
		end
	end

endmodule // dcbs_ret_ram

// >>> rtl/dcbs_top.sv
/*
 * Dual-core boot sequencer: strap and fuse capture, boot decision for the
 * low-power core, power-up and reset release of the fast core, sticky boot
 * cause flags, retention SRAM, memory-map decoder with security attribution,
 * and an Avalon-MM register slave with one level interrupt.
 * Assumes all inputs are synchronous to clk; rst is a hardware reset, por is
 * asserted together with rst only on a full power-on.
 */
`timescale 1ns/1ps
module dcbs_top import dcbs_pkg::*; #(
	parameter int RRAM_WORDS = 256
) (
	// Clock and resets
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        por,
	// Avalon-MM register slave
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Interrupt
	output logic             irq,
	// Straps and fuses
	input  wire logic        download_strap_pin,
	input  wire logic        xtal_fuse_26m,
	input  wire logic        user_image_valid,
	// Reset cause events, one-cycle pulses
	input  wire dcbs_cause_t cause_evt,
	// Fast core bring-up handshake
	input  wire logic        pll_locked,
	input  wire logic        flash_cal_done,
	input  wire logic        fast_pwr_good,
	output dcbs_pwr_t        pwr_ctl,
	// Core control
	output logic             slow_core_rst_n,
	output logic             fast_core_rst_n,
	output logic      [31:0] slow_core_vector,
	output logic      [31:0] fast_core_vector,
	output logic             clk_sel_26m,
	output logic             isp_mode,
	// Address decoder probe
	input  wire logic [31:0] probe_addr,
	output dcbs_probe_t      probe_out
);

	// ------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------
	localparam int AW = $clog2(RRAM_WORDS);

	if (RRAM_WORDS < 2 || RRAM_WORDS > 256 || (1 << AW) != RRAM_WORDS) begin : g_bad
		$error("dcbs_top: RRAM_WORDS must be a power of two from 2 to 256");
	end

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	// Inclusive-base, exclusive-end window test
	function automatic logic in_win(input logic [31:0] a, input logic [31:0] b,
	                                input logic [31:0] s);
		in_win = (a >= b) && ((a - b) < s);
	endfunction

	// Region lookup for a system address
	function automatic dcbs_region_t region_of(input logic [31:0] a);
		if (in_win(a, FAST_SRAM_BASE, FAST_SRAM_SIZE))      region_of = RGN_FAST_SRAM;
		else if (in_win(a, SLOW_SRAM_BASE, SLOW_SRAM_SIZE)) region_of = RGN_SLOW_SRAM;
		else if (in_win(a, PSRAM_BASE, PSRAM_SIZE))         region_of = RGN_PSRAM;
		else if (in_win(a, RET_SRAM_BASE, RET_SRAM_SIZE))   region_of = RGN_RET_SRAM;
		else                                                region_of = RGN_NONE;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	dcbs_state_t       state_reg, state_next;    // Boot sequencer
	logic [1:0]        phase_reg;                // Bus access phase
	logic [IRQ_W-1:0]  irq_stat_reg, irq_stat_next;
	logic [IRQ_W-1:0]  irq_mask_reg;
	dcbs_cause_t       cause_reg, cause_next;    // Sticky boot cause
	logic [31:0]       sau_base_reg, sau_limit_reg;
	logic              sau_en_reg;
	logic              go_reg;                   // Bring-up request from software
	logic [31:0]       rram_q;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire        bus_req   = avs_read || avs_write;
	wire        wr_fire   = avs_write && (phase_reg == 2'h2);  // Commit at answer edge
	wire        rram_hit  = (avs_address[11:10] == RRAM_WIN_SEL);
	wire        hit_ctrl  = wr_fire && (avs_address == OFS_CTRL);
	wire        hit_istat = wr_fire && (avs_address == OFS_IRQ_STAT);
	wire        hit_imask = wr_fire && (avs_address == OFS_IRQ_MASK);
	wire        hit_base  = wr_fire && (avs_address == OFS_SAU_BASE);
	wire        hit_limit = wr_fire && (avs_address == OFS_SAU_LIMIT);
	wire        hit_sctl  = wr_fire && (avs_address == OFS_SAU_CTRL);
	wire [31:0] status_w  = {24'h0, fast_core_rst_n, isp_mode, clk_sel_26m, 1'b0, state_reg};
	wire [31:0] rd_mux    =
		rram_hit                      ? rram_q :
		(avs_address == OFS_CTRL)     ? {31'h0, go_reg} :
		(avs_address == OFS_STATUS)   ? status_w :
		(avs_address == OFS_CAUSE)    ? {26'h0, cause_reg} :
		(avs_address == OFS_IRQ_STAT) ? {29'h0, irq_stat_reg} :
		(avs_address == OFS_IRQ_MASK) ? {29'h0, irq_mask_reg} :
		(avs_address == OFS_SAU_BASE) ? sau_base_reg :
		(avs_address == OFS_SAU_LIMIT)? sau_limit_reg :
		(avs_address == OFS_SAU_CTRL) ? {31'h0, sau_en_reg} : 32'h0;  // Unmapped reads zero

	// Bus phase: 0 idle, 1 read RAM, 2 answer
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_reg       <= 2'h0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else begin
			phase_reg       <= (phase_reg == 2'h0) ? {1'b0, bus_req} :
			                   (phase_reg == 2'h1) ? 2'h2 : 2'h0;
			avs_waitrequest <= (phase_reg != 2'h1);
			if (phase_reg == 2'h1) begin
				avs_readdata <= rd_mux;  // RAM word is valid here
			end
		end
	end

	// ------------------------------------------------------------------
	// Retention SRAM, no reset so it keeps data through deep sleep
	// ------------------------------------------------------------------
	dcbs_ret_ram #(
		.WORDS (RRAM_WORDS),
		.AW    (AW)
	) u_rram (
		.clk   (clk),
		.we    (wr_fire && rram_hit),
		.be    (avs_byteenable),
		.addr  (avs_address[AW+1:2]),
		.wdata (avs_writedata),
		.rdata (rram_q)
	);

	// ------------------------------------------------------------------
	// Boot sequencer
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// Strap seen high means flash boot, low means ISP
			ST_SAMPLE: state_next = download_strap_pin ? ST_SEARCH : ST_ISP;
			ST_ISP:    state_next = ST_ISP;
			// Valid image runs, otherwise park the core
			ST_SEARCH: state_next = user_image_valid ? ST_USER : ST_DEAD;
			ST_USER:   state_next = go_reg ? ST_PLL : ST_USER;
			ST_DEAD:   state_next = ST_DEAD;
			// Fast core bring-up steps, in fixed order
			ST_PLL:    state_next = pll_locked ? ST_FCAL : ST_PLL;
			ST_FCAL:   state_next = flash_cal_done ? ST_PWR : ST_FCAL;
			ST_PWR:    state_next = fast_pwr_good ? ST_RUN : ST_PWR;
			ST_RUN:    state_next = ST_RUN;
			default:   state_next = ST_SAMPLE;
		endcase
	end

	// Sequencer and core controls
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg       <= ST_SAMPLE;
			slow_core_rst_n <= 1'b0;
			fast_core_rst_n <= 1'b0;
			isp_mode        <= 1'b0;
			clk_sel_26m     <= 1'b0;
			pwr_ctl         <= '0;
		end else begin
			state_reg <= state_next;
			// Straps are caught on the first edge after release, not under reset
			if (state_reg == ST_SAMPLE) begin
				isp_mode        <= !download_strap_pin;
				clk_sel_26m     <= xtal_fuse_26m;
				slow_core_rst_n <= 1'b1;
			end
			pwr_ctl.pll_pwr_en    <= (state_next >= ST_PLL);
			pwr_ctl.flash_cal_req <= (state_next == ST_FCAL);
			pwr_ctl.fast_pwr_en   <= (state_next >= ST_PWR);
			fast_core_rst_n       <= (state_next == ST_RUN);
		end
	end

	// Vectors are constants; no register can reach them
	always_ff @(posedge clk) begin
		slow_core_vector <= VEC_SLOW_CORE;
		fast_core_vector <= VEC_FAST_CORE;
	end

	// ------------------------------------------------------------------
	// Boot cause flags and interrupt
	// ------------------------------------------------------------------
	// Only power-on clears; a new event in that cycle still lands
	assign cause_next = (por ? '0 : cause_reg) | cause_evt;

	// Set wins over the write-one-to-clear
	assign irq_stat_next = (irq_stat_reg & ~(hit_istat ? avs_writedata[IRQ_W-1:0] : '0))
		| {(|cause_evt),
		   (state_reg == ST_SEARCH && state_next == ST_DEAD),
		   (state_reg == ST_PWR && state_next == ST_RUN)};

	// Cause register ignores rst: it must outlive warm resets
	always_ff @(posedge clk) begin
		cause_reg <= cause_next;
	end

	// Interrupt status, mask and output
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= RST_IRQ_MASK;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (hit_imask) begin
				irq_mask_reg <= avs_writedata[IRQ_W-1:0];
			end
			irq <= |(irq_stat_reg & irq_mask_reg);  // One cycle behind status
		end
	end

	// ------------------------------------------------------------------
	// Control and security attribution registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			go_reg        <= 1'b0;
			sau_en_reg    <= 1'b0;                 // Everything secure at boot
			sau_base_reg  <= RST_SAU_WORD;
			sau_limit_reg <= RST_SAU_WORD;
		end else begin
			if (hit_ctrl)  go_reg        <= avs_writedata[CTRL_GO_BIT];
			if (hit_sctl)  sau_en_reg    <= avs_writedata[SAU_EN_BIT];
			if (hit_base)  sau_base_reg  <= avs_writedata;
			if (hit_limit) sau_limit_reg <= avs_writedata;
		end
	end

	// ------------------------------------------------------------------
	// Address decoder probe
	// ------------------------------------------------------------------
	wire ns_hit = sau_en_reg && (probe_addr >= sau_base_reg) && (probe_addr <= sau_limit_reg);

	always_ff @(posedge clk) begin
		if (rst) begin
			probe_out <= '{RGN_NONE, 1'b1};
		end else begin
			probe_out.region <= region_of(probe_addr);
			probe_out.secure <= !ns_hit;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_fast_rst_order: assert property ($rose(fast_core_rst_n) |->
		pwr_ctl.pll_pwr_en && pwr_ctl.fast_pwr_en && $past(fast_pwr_good))
		else $error("fast core released before power steps");
	a_fast_vec_fix: assert property ($rose(fast_core_rst_n) |->
		fast_core_vector == VEC_FAST_CORE)
		else $error("fast core vector wrong at release");
	a_slow_only_boot: assert property ($rose(slow_core_rst_n) |->
		!fast_core_rst_n && slow_core_vector == VEC_SLOW_CORE)
		else $error("slow core not alone at boot");
	a_clk_pick: assert property (!rst && state_reg == ST_SAMPLE |=>
		clk_sel_26m == $past(xtal_fuse_26m))
		else $error("clock choice not from fuse");
	a_strap_isp: assert property (!rst && state_reg == ST_SAMPLE && !download_strap_pin |=>
		isp_mode && state_reg == ST_ISP ##1 state_reg == ST_ISP)
		else $error("low strap did not enter ISP");
	a_user_search: assert property (state_reg == ST_SEARCH |=>
		state_reg == ($past(user_image_valid) ? ST_USER : ST_DEAD))
		else $error("image search went wrong way");
	a_cause_keep: assert property (!por && cause_evt == '0 |=>
		cause_reg == $past(cause_reg))
		else $error("cause flags changed without event");
	a_cause_set: assert property (cause_evt.cause_brownout |=>
		cause_reg.cause_brownout)
		else $error("brownout flag not recorded");
	a_secure_dflt: assert property (!sau_en_reg |=> probe_out.secure)
		else $error("address non-secure while unit off");
	a_dec_fast: assert property (probe_addr == FAST_SRAM_BASE + FAST_SRAM_SIZE - 32'h1 |=>
		probe_out.region == RGN_FAST_SRAM)
		else $error("fast SRAM top not decoded");
	a_bus_answer: assert property (bus_req && phase_reg == 2'h0 |->
		avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not on third edge");

	c_isp_boot:   cover property (state_reg == ST_SAMPLE && !download_strap_pin);
	c_fast_up:    cover property ($rose(fast_core_rst_n));
	c_dead_loop:  cover property (state_reg == ST_DEAD);
	c_rram_write: cover property (wr_fire && rram_hit);

endmodule // dcbs_top

// >>> verification/dcbs_host_model.sv
/*
 * Host-side model for the boot sequencer: holds the download strap and
 * answers the fast core bring-up handshake, promptly or slowly.
 * Assumes the sequencer's clock and synchronous reset.
 */
`timescale 1ns/1ps
module dcbs_host_model import dcbs_pkg::*; #(
	parameter int SLOW_DLY = 20                // Answer delay in slow mode
) (
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      rst,
	// Bench control
	input  wire logic      strap_req,
	input  wire logic      slow,
	// Sequencer side
	input  wire dcbs_pwr_t pwr_ctl,
	output logic           download_strap_pin,
	output logic           pll_locked,
	output logic           flash_cal_done,
	output logic           fast_pwr_good
);
	logic [7:0] pll_cnt;                          // Cycles the PLL request stood
	logic [7:0] cal_cnt;                          // Cycles calibration stood
	logic [7:0] pg_cnt;                           // Cycles core power stood
	wire  [7:0] dly = slow ? 8'(SLOW_DLY) : 8'h1; // Current answer delay

	// Saturating count, so a long run never drops an answer
	function automatic logic [7:0] bump(logic req, logic [7:0] c);
		return req ? c + 8'(c != 8'hff) : 8'h0;
	endfunction

	// Strap level stands through reset and its release
	assign download_strap_pin = strap_req;
	// Each answer follows only its own request
	assign pll_locked     = pll_cnt >= dly;
	assign flash_cal_done = cal_cnt >= dly;
	assign fast_pwr_good  = pg_cnt >= dly;

	// ------------------------------------------------------------------
	// Request age counters
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pll_cnt <= 8'h0;
			cal_cnt <= 8'h0;
			pg_cnt  <= 8'h0;
		end else begin
			pll_cnt <= bump(pwr_ctl.pll_pwr_en, pll_cnt);
			cal_cnt <= bump(pwr_ctl.flash_cal_req, cal_cnt);
			pg_cnt  <= bump(pwr_ctl.fast_pwr_en, pg_cnt);
		end
	end
endmodule // dcbs_host_model

// >>> verification/dcbs_top_tb.sv
/*
 * Self-checking bench for the boot sequencer: boot modes, bring-up, decoder,
 * cause flags and retention SRAM, registers reached through the Avalon-MM slave and the decoder through its probe port.
 * Assumes dcbs_pkg and the host model are compiled first.
 */
`timescale 1ns/1ps
module dcbs_top_tb import dcbs_pkg::*; ;
	logic        clk = 1'b0, rst = 1'b1, por = 1'b1;
	logic [11:0] avs_address = 12'h0;
	logic        avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, probe_addr = 32'h0, avs_readdata, rd;
	logic [3:0]  avs_byteenable = 4'hf;
	logic        strap_req = 1'b1, slow = 1'b0, xtal = 1'b1, img_ok = 1'b1;
	logic        avs_waitrequest, irq, strap, pll_ok, cal_ok, pwr_ok;
	logic        slow_rst_n, fast_rst_n, clk26, isp;
	logic [31:0] vec_s, vec_f;
	dcbs_cause_t cause_evt = '0;
	dcbs_pwr_t   pwr_ctl;
	dcbs_probe_t probe_out;
	int          bad_count = 0, check_count = 0, cyc = 0;
	// Decoder boundaries: first, last and first-past address of each region
	logic [31:0] pa [13] = '{32'h0008_0000, 32'h0008_ffff, 32'h0009_0000, 32'h000c_0000,
		32'h000c_03ff, 32'h000c_0400, 32'h0200_0000, 32'h023f_ffff, 32'h0240_0000,
		32'h1000_0000, 32'h1007_ffff, 32'h1008_0000, 32'h0000_0000};
	logic [2:0]  pr [13] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0, 3'h3, 3'h3, 3'h0,
		3'h4, 3'h4, 3'h0, 3'h0};

	dcbs_top uut (.clk(clk), .rst(rst), .por(por), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .download_strap_pin(strap),
		.xtal_fuse_26m(xtal), .user_image_valid(img_ok), .cause_evt(cause_evt),
		.pll_locked(pll_ok), .flash_cal_done(cal_ok), .fast_pwr_good(pwr_ok),
		.pwr_ctl(pwr_ctl), .slow_core_rst_n(slow_rst_n), .fast_core_rst_n(fast_rst_n),
		.slow_core_vector(vec_s), .fast_core_vector(vec_f), .clk_sel_26m(clk26),
		.isp_mode(isp), .probe_addr(probe_addr), .probe_out(probe_out));
	dcbs_host_model host (.clk(clk), .rst(rst), .strap_req(strap_req), .slow(slow),
		.pwr_ctl(pwr_ctl), .download_strap_pin(strap), .pll_locked(pll_ok),
		.flash_cal_done(cal_ok), .fast_pwr_good(pwr_ok));

	// ------------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------------
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	// Compare and count
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(logic wr, logic [11:0] a, logic [31:0] d = 0, logic [3:0] be = 4'hf);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	// Five-cycle reset, then three edges for the boot decision to settle
	task automatic do_reset(logic p);
		@(posedge clk);
		rst <= 1'b1;
		por <= p;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic probe(logic [31:0] a, logic [3:0] exp);
		@(posedge clk);
		probe_addr <= a;
		repeat (2) @(posedge clk);
		chk("probe", 32'(probe_out), 32'(exp));
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Every strap and fuse combination, image valid tied to the fuse; strap moved after sampling
	task automatic t_boot;
		logic [3:0] st;
		for (int i = 0; i < 4; i++) begin
			strap_req <= i[0];
			xtal <= i[1];
			img_ok <= i[1];
			do_reset(1'b0);
			st = i[0] ? (i[1] ? 4'h3 : 4'h4) : 4'h1;
			chk("vec_slow", vec_s, 32'h0000_0000);
			chk("vec_fast", vec_f, 32'h1010_0000);
			chk("core_rst", 32'({slow_rst_n, fast_rst_n}), 32'h2);
			chk("clk26", 32'(clk26), 32'(i[1]));
			bus(1'b0, OFS_STATUS);
			chk("status", rd, {24'h0, 1'b0, !i[0], i[1], 1'b0, st});
			bus(1'b0, OFS_IRQ_STAT);
			chk("dead_irq", rd, {30'h0, st == 4'h4, 1'b0});
			strap_req <= !i[0];
			repeat (2) @(posedge clk);
			chk("isp_hold", 32'(isp), 32'(!i[0]));
			if (st != 4'h3) begin
				bus(1'b1, OFS_CTRL, 32'h1);
				repeat (2) @(posedge clk);
				chk("go_refused", 32'(pwr_ctl), 32'h0);
			end
		end
		$display("boot test done");
	endtask

	// Bring-up with a prompt and a slow host, then the interrupt path
	task automatic t_bringup;
		int n;
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			strap_req <= 1'b1;
			img_ok <= 1'b1;
			do_reset(1'b0);
			chk("pwr_idle", 32'(pwr_ctl), 32'h0);
			bus(1'b1, OFS_IRQ_STAT, 32'h7);
			bus(1'b1, OFS_IRQ_MASK, 32'h1);
			bus(1'b1, OFS_CTRL, 32'h1);
			n = 0;
			while (fast_rst_n !== 1'b1 && n < 300) begin
				@(posedge clk);
				n++;
			end
			chk("release", 32'({pwr_ctl, pwr_ok}), 32'hb);
			chk("late", 32'(n >= (s ? 55 : 3)), 32'h1);
			repeat (3) @(posedge clk);
			chk("irq_up", 32'(irq), 32'h1);
			bus(1'b1, OFS_IRQ_MASK, 32'h0);
			bus(1'b1, OFS_IRQ_STAT, 32'h1);
			bus(1'b1, OFS_IRQ_MASK, 32'h1);
			repeat (2) @(posedge clk);
			chk("irq_clr", 32'(irq), 32'h0);
		end
		$display("bring-up test done");
	endtask

	// Region edges, then one non-secure window
	task automatic t_decode;
		do_reset(1'b0);
		for (int i = 0; i < 13; i++) probe(pa[i], {pr[i], 1'b1});
		bus(1'b1, OFS_SAU_BASE, 32'h1000_0000);
		bus(1'b1, OFS_SAU_LIMIT, 32'h1000_0fff);
		bus(1'b1, OFS_SAU_CTRL, 32'h1);
		probe(32'h1000_0fff, 4'h8);
		probe(32'h1000_1000, 4'h9);
		$display("decode test done");
	endtask

	// Each cause flag alone, read-only, unmapped, warm and power-on resets
	task automatic t_cause;
		do_reset(1'b1);
		bus(1'b1, OFS_IRQ_MASK, 32'h4);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			cause_evt <= dcbs_cause_t'(6'h1 << i);
			@(posedge clk);
			cause_evt <= '0;
			bus(1'b0, OFS_CAUSE);
			chk("cause", rd, (32'h2 << i) - 32'h1);
		end
		chk("cause_irq", 32'(irq), 32'h1);
		bus(1'b1, OFS_CAUSE, 32'h0);
		bus(1'b0, 12'h100);
		chk("unmapped", rd, 32'h0);
		do_reset(1'b0);
		bus(1'b0, OFS_CAUSE);
		chk("cause_warm", rd, 32'h3f);
		do_reset(1'b1);
		bus(1'b0, OFS_CAUSE);
		chk("cause_por", rd, 32'h0);
		$display("cause test done");
	endtask

	// Byte-lane write and survival of a warm reset
	task automatic t_rram;
		bus(1'b1, 12'h400, 32'h1234_5678);
		bus(1'b1, 12'h400, 32'hffff_ffff, 4'h1);
		bus(1'b1, 12'h7fc, 32'ha5a5_0f0f);
		do_reset(1'b0);
		bus(1'b0, 12'h400);
		chk("rram_lo", rd, 32'h1234_56ff);
		bus(1'b0, 12'h7fc);
		chk("rram_hi", rd, 32'ha5a5_0f0f);
		$display("retention test done");
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		do_reset(1'b1);
		t_boot();
		t_bringup();
		t_decode();
		t_cause();
		t_rram();
		print_verdict();
	end
endmodule // dcbs_top_tb
